// [hw/fmac_regs.svh]
`ifndef FMAC_REGS_SVH
`define FMAC_REGS_SVH

// ------------------------------------------------------------
// Number format
// ------------------------------------------------------------
`define FMAC_SIGN_BIT   15
`define FMAC_EXP_HI     14
`define FMAC_EXP_LO     9
`define FMAC_MAN_HI     8
`define FMAC_EXP_BIAS   9'sd31
`define FMAC_EXP_SPEC   6'h3f
`define FMAC_EXP_MAXFIN 6'h3e
`define FMAC_EXP_MINNRM 6'h01
`define FMAC_EXP_ZERO   6'h00
`define FMAC_MAN_ONES   9'h1ff
`define FMAC_MAN_ZERO   9'h000
`define FMAC_EXP_LIMIT  9'sd63

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define FMAC_WORD_RST   16'h0000
`define FMAC_BYTE_RST   8'h00
`define FMAC_OE_OFF     8'h00

`endif

// [hw/fmac_pkg.sv]
package fmac_pkg;
   typedef logic [15:0] fmac_word_t;
   typedef logic [7:0]  fmac_byte_t;

   // Operand load sequencer
   typedef enum logic [1:0] {
      FMAC_LOAD_A = 2'b01,
      FMAC_LOAD_B = 2'b10
   } fmac_load_e;
endpackage

// [hw/fmac_mac.sv]
`include "fmac_regs.svh"

module fmac_mac (
   input  wire logic                CLK_IN,              // 10 MHz system clock
   input  wire logic                RST_N_IN,            // Sync reset, active low
   input  wire fmac_pkg::fmac_byte_t OPERAND_LOW_PORT_IN, // Operand bits 7:0
   input  wire fmac_pkg::fmac_byte_t OPERAND_HIGH_IN,     // Operand bits 15:8 (bidir in)
   output wire fmac_pkg::fmac_byte_t OPERAND_HIGH_OUT,    // Bidir output value, unused
   output wire fmac_pkg::fmac_byte_t OPERAND_HIGH_OE_OUT, // Bidir enables, always low
   output wire fmac_pkg::fmac_byte_t RESULT_BYTE_PORT_OUT // Result byte, high then low
);
   import fmac_pkg::*;

   // ------------------------------------------------------------
   // Arithmetic
   // ------------------------------------------------------------
   function automatic logic is_special(input fmac_word_t w);
      is_special = (w[`FMAC_EXP_HI:`FMAC_EXP_LO] == `FMAC_EXP_SPEC);
   endfunction

   function automatic logic is_zero(input fmac_word_t w);
      is_zero = (w[`FMAC_EXP_HI:`FMAC_EXP_LO] == `FMAC_EXP_ZERO);
   endfunction

   function automatic fmac_word_t sat_max(input logic s);
      sat_max = {s, `FMAC_EXP_MAXFIN, `FMAC_MAN_ONES};
   endfunction

   function automatic fmac_word_t inf_nan(input logic s);
      inf_nan = {s, `FMAC_EXP_SPEC, `FMAC_MAN_ONES};
   endfunction

   function automatic fmac_word_t fp_mul(input fmac_word_t a, input fmac_word_t b);
      logic              s;
      logic [19:0]       p;
      logic signed [8:0] e;
      logic [8:0]        m;
      logic              g;
      logic              st;
      logic [9:0]        r;
      begin
         s = a[`FMAC_SIGN_BIT] ^ b[`FMAC_SIGN_BIT];
         p = {1'b1, a[`FMAC_MAN_HI:0]} * {1'b1, b[`FMAC_MAN_HI:0]};
         e = $signed({3'b000, a[`FMAC_EXP_HI:`FMAC_EXP_LO]})
           + $signed({3'b000, b[`FMAC_EXP_HI:`FMAC_EXP_LO]}) - `FMAC_EXP_BIAS;
         if (p[19]) begin
            m  = p[18:10];
            g  = p[9];
            st = |p[8:0];
            e  = e + 9'sd1;
         end else begin
            m  = p[17:9];
            g  = p[8];
            st = |p[7:0];
         end
         r = {1'b0, m} + {9'h000, g & (st | m[0])};
         if (r[9]) begin
            e = e + 9'sd1;
            m = `FMAC_MAN_ZERO;
         end else begin
            m = r[8:0];
         end
         if (is_special(a) || is_special(b)) begin
            fp_mul = inf_nan(s);
         end else if (is_zero(a) || is_zero(b)) begin
            fp_mul = `FMAC_WORD_RST;
         end else if (e >= `FMAC_EXP_LIMIT) begin
            fp_mul = sat_max(s);
         end else if (e <= 9'sd0) begin
            fp_mul = `FMAC_WORD_RST;
         end else begin
            fp_mul = {s, e[5:0], m};
         end
      end
   endfunction

   function automatic fmac_word_t fp_add(input fmac_word_t a, input fmac_word_t b);
      fmac_word_t        x;
      fmac_word_t        y;
      logic [13:0]       mx;
      logic [13:0]       my;
      logic [13:0]       sm;
      logic [5:0]        d;
      logic signed [8:0] e;
      logic              st;
      logic [9:0]        r;
      logic [8:0]        m;
      begin
         x  = (a[14:0] >= b[14:0]) ? a : b;
         y  = (a[14:0] >= b[14:0]) ? b : a;
         d  = x[`FMAC_EXP_HI:`FMAC_EXP_LO] - y[`FMAC_EXP_HI:`FMAC_EXP_LO];
         mx = {2'b01, x[`FMAC_MAN_HI:0], 3'b000};
         my = {2'b01, y[`FMAC_MAN_HI:0], 3'b000};
         st = 1'b0;
         for (int i = 0; i < 13; i++) begin
            if (i < int'(d)) begin
               st = st | my[0];
               my = my >> 1;
            end
         end
         my[0] = my[0] | st;
         sm = (x[`FMAC_SIGN_BIT] == y[`FMAC_SIGN_BIT]) ? mx + my : mx - my;
         e  = $signed({3'b000, x[`FMAC_EXP_HI:`FMAC_EXP_LO]});
         if (sm[13]) begin
            sm = {1'b0, sm[13:1]} | {13'h0000, sm[0]};
            e  = e + 9'sd1;
         end
         for (int i = 0; i < 12; i++) begin
            if (!sm[12] && (sm != 14'h0000)) begin
               sm = sm << 1;
               e  = e - 9'sd1;
            end
         end
         r = {1'b0, sm[11:3]} + {9'h000, sm[2] & ((|sm[1:0]) | sm[3])};
         if (r[9]) begin
            e = e + 9'sd1;
            m = `FMAC_MAN_ZERO;
         end else begin
            m = r[8:0];
         end
         if (is_special(a) || is_special(b)) begin
            fp_add = inf_nan(is_special(a) ? a[`FMAC_SIGN_BIT] : b[`FMAC_SIGN_BIT]);
         end else if (is_zero(a)) begin
            fp_add = b;
         end else if (is_zero(b)) begin
            fp_add = a;
         end else if (sm == 14'h0000) begin
            fp_add = `FMAC_WORD_RST;
         end else if (e >= `FMAC_EXP_LIMIT) begin
            fp_add = sat_max(x[`FMAC_SIGN_BIT]);
         end else if (e <= 9'sd0) begin
            fp_add = {x[`FMAC_SIGN_BIT], `FMAC_EXP_MINNRM, `FMAC_MAN_ZERO};
         end else begin
            fp_add = {x[`FMAC_SIGN_BIT], e[5:0], m};
         end
      end
   endfunction

   // ------------------------------------------------------------
   // Stage 1 and 2: operand capture
   // ------------------------------------------------------------
   fmac_load_e load_r;
   fmac_load_e load_nxt;
   fmac_word_t opa_r;
   fmac_word_t opb_r;
   logic       pair_vld_r;
   wire        fmac_word_t operand_bits = {OPERAND_HIGH_IN, OPERAND_LOW_PORT_IN};

   always_comb begin
      case (load_r)
         FMAC_LOAD_A: load_nxt = FMAC_LOAD_B;
         FMAC_LOAD_B: load_nxt = FMAC_LOAD_A;
         default:     load_nxt = FMAC_LOAD_A;
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         load_r     <= FMAC_LOAD_A;
         opa_r      <= `FMAC_WORD_RST;
         opb_r      <= `FMAC_WORD_RST;
         pair_vld_r <= 1'b0;
      end else begin
         load_r     <= load_nxt;
         pair_vld_r <= (load_r == FMAC_LOAD_B);
         if (load_r == FMAC_LOAD_A) begin
            opa_r <= operand_bits;
         end
         if (load_r == FMAC_LOAD_B) begin
            opb_r <= operand_bits;
         end
      end
   end

   // ------------------------------------------------------------
   // Stage 3: multiply
   // ------------------------------------------------------------
   fmac_word_t prod_r;
   logic       prod_vld_r;
   wire        fmac_word_t prod_nxt = fp_mul(opa_r, opb_r);

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         prod_r     <= `FMAC_WORD_RST;
         prod_vld_r <= 1'b0;
      end else begin
         prod_vld_r <= pair_vld_r;
         if (pair_vld_r) begin
            prod_r <= prod_nxt;
         end
      end
   end

   // ------------------------------------------------------------
   // Stage 4: accumulate
   // ------------------------------------------------------------
   fmac_word_t acc_r;
   logic       acc_vld_r;
   wire        fmac_word_t acc_nxt = fp_add(acc_r, prod_r);

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         acc_r     <= `FMAC_WORD_RST;
         acc_vld_r <= 1'b0;
      end else begin
         acc_vld_r <= prod_vld_r;
         if (prod_vld_r) begin
            acc_r <= acc_nxt;
         end
      end
   end

   // ------------------------------------------------------------
   // Stage 5: byte-serial result
   // ------------------------------------------------------------
   fmac_byte_t out_r;
   wire        fmac_byte_t out_nxt = acc_vld_r ? acc_r[15:8] : acc_r[7:0];

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         out_r <= `FMAC_BYTE_RST;
      end else begin
         out_r <= out_nxt;
      end
   end

   assign RESULT_BYTE_PORT_OUT = out_r;
   assign OPERAND_HIGH_OUT     = `FMAC_BYTE_RST;
   assign OPERAND_HIGH_OE_OUT  = `FMAC_OE_OFF;

endmodule // fmac_mac

// [testbench/fmac_chk.sv]
module fmac_chk (
   input wire logic                 CLK_IN,               // Clock
   input wire logic                 RST_N_IN,             // Sync reset
   input wire fmac_pkg::fmac_byte_t OPERAND_LOW_PORT_IN,  // Operand low
   input wire fmac_pkg::fmac_byte_t OPERAND_HIGH_IN,      // Operand high
   input wire fmac_pkg::fmac_byte_t OPERAND_HIGH_OUT,     // Bidir value
   input wire fmac_pkg::fmac_byte_t OPERAND_HIGH_OE_OUT,  // Bidir enables
   input wire fmac_pkg::fmac_byte_t RESULT_BYTE_PORT_OUT  // Result byte
);
   timeunit 1ns;
   timeprecision 1ns;
   import fmac_pkg::*;
   wire fmac_word_t op = {OPERAND_HIGH_IN, OPERAND_LOW_PORT_IN};
   logic            ph_r;
   logic            first_r;
   // ---------------------------------------------
   // Operand phase since reset
   // ---------------------------------------------
   always_ff @(posedge CLK_IN) begin
      ph_r    <= RST_N_IN ? ~ph_r : 1'b0;
      first_r <= ~RST_N_IN;
   end
   default clocking cb @(posedge CLK_IN); endclocking
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   bidir_off_a: assert property (
      OPERAND_HIGH_OE_OUT == 8'h00 && OPERAND_HIGH_OUT == 8'h00) else $error("bidir driven");
   rst_clear_a: assert property (
      !RST_N_IN |=> RESULT_BYTE_PORT_OUT == 8'h00) else $error("output not cleared");
   zero_in_a: assert property (disable iff (!RST_N_IN)
      first_r && op == 16'h0000 |-> ##2 (RESULT_BYTE_PORT_OUT == 8'h00) [*5]) else $error("zero operand");
   first_res_a: assert property (disable iff (!RST_N_IN)
      first_r && op == 16'h3e00 ##1 op == 16'h3e00 |-> ##4 RESULT_BYTE_PORT_OUT == 8'h3e
      ##1 RESULT_BYTE_PORT_OUT == 8'h00) else $error("first result");
   inf_code_a: assert property (disable iff (!RST_N_IN)
      !ph_r && op[14:9] == 6'h3f |-> ##5 RESULT_BYTE_PORT_OUT[6:0] == 7'h7f
      ##1 RESULT_BYTE_PORT_OUT == 8'hff) else $error("special code");
   mul_sat_a: assert property (disable iff (!RST_N_IN)
      first_r && op == 16'h7dff ##1 op == 16'h7dff |-> ##4 RESULT_BYTE_PORT_OUT == 8'h7d
      ##1 RESULT_BYTE_PORT_OUT == 8'hff) else $error("no saturation");
   mul_flush_a: assert property (disable iff (!RST_N_IN)
      first_r && op == 16'h0200 ##1 op == 16'h0200 |-> ##4 RESULT_BYTE_PORT_OUT == 8'h00
      ##1 RESULT_BYTE_PORT_OUT == 8'h00) else $error("no flush");
   small_res_a: assert property (disable iff (!RST_N_IN)
      first_r && op == 16'h0201 ##1 op == 16'h3e00 |-> ##4 RESULT_BYTE_PORT_OUT == 8'h02
      ##1 RESULT_BYTE_PORT_OUT == 8'h01) else $error("bad product");
endmodule // fmac_chk

bind fmac_mac fmac_chk chk (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .OPERAND_LOW_PORT_IN(OPERAND_LOW_PORT_IN),
   .OPERAND_HIGH_IN(OPERAND_HIGH_IN), .OPERAND_HIGH_OUT(OPERAND_HIGH_OUT),
   .OPERAND_HIGH_OE_OUT(OPERAND_HIGH_OE_OUT), .RESULT_BYTE_PORT_OUT(RESULT_BYTE_PORT_OUT));

// [testbench/fmac_fpga.sv]
module fmac_fpga (
   input  wire logic        clk_in,     // Clock
   input  wire logic [15:0] word_in,    // Operand to send
   input  wire logic [7:0]  oe_in,      // Device bidir enables
   input  wire logic [7:0]  dev_hi_in,  // Device bidir values
   input  wire logic [7:0]  byte_in,    // Result byte
   output wire logic [7:0]  lo_out,     // Low operand byte
   output wire logic [7:0]  hi_out,     // Bidir wire level
   output wire logic [15:0] joined_out  // Last two bytes, high first
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last_r;
   assign lo_out = word_in[7:0];
   assign hi_out = (oe_in & dev_hi_in) | (~oe_in & word_in[15:8]);
   always_ff @(posedge clk_in) last_r <= byte_in;
   assign joined_out = {last_r, byte_in};
endmodule // fmac_fpga

// [testbench/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import fmac_pkg::*;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   fmac_word_t word = 16'h0000;
   fmac_word_t joined;
   fmac_byte_t lo, hi, hi_o, oe, res;
   int         err_total = 0;
   int         num_checks = 0;
   always #50 clk = ~clk;
   fmac_fpga fpga (.clk_in(clk), .word_in(word), .oe_in(oe), .dev_hi_in(hi_o), .byte_in(res),
      .lo_out(lo), .hi_out(hi), .joined_out(joined));
   fmac_mac uut (.CLK_IN(clk), .RST_N_IN(rst_n), .OPERAND_LOW_PORT_IN(lo), .OPERAND_HIGH_IN(hi),
      .OPERAND_HIGH_OUT(hi_o), .OPERAND_HIGH_OE_OUT(oe), .RESULT_BYTE_PORT_OUT(res));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic cmp(input string name, input fmac_word_t exp_v);
      num_checks++;
      if (joined !== exp_v) begin
         $display("wrong value %s expected %h seen %h", name, exp_v, joined);
         err_total++;
      end
   endtask
   // Reset, two pairs back to back, then zero operands
   task automatic run(input string name, input fmac_word_t a0, b0, a1, b1, e0, e1);
      rst_n = 1'b0;
      word = 16'h0000;
      @(negedge clk);
      rst_n = 1'b1;
      word = a0;
      @(negedge clk) word = b0;
      @(negedge clk) word = a1;
      @(negedge clk) word = b1;
      @(negedge clk) word = 16'h0000;
      repeat (2) @(negedge clk);
      cmp({name, " first"}, e0);
      repeat (2) @(negedge clk);
      cmp({name, " second"}, e1);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic s_accum; run("accum", 16'h3e00, 16'h3e00, 16'h3e00, 16'h4000, 16'h3e00, 16'h4100); endtask
   task automatic s_cancel; run("cancel", 16'h3e00, 16'h3e00, 16'hbe00, 16'h3e00, 16'h3e00, 16'h0000); endtask
   task automatic s_round; run("round", 16'h3e01, 16'h3e01, 16'h3e01, 16'h3f00, 16'h3e02, 16'h4082); endtask
   task automatic s_ovf; run("ovf", 16'h7dff, 16'h7dff, 16'h7dff, 16'h3e00, 16'h7dff, 16'h7dff); endtask
   task automatic s_flush; run("flush", 16'h0200, 16'h0200, 16'h3e00, 16'h3e00, 16'h0000, 16'h3e00); endtask
   task automatic s_addund; run("addund", 16'h0201, 16'h3e00, 16'h8200, 16'h3e00, 16'h0201, 16'h0200); endtask
   task automatic s_special; run("special", 16'h7e00, 16'h3e00, 16'h3e00, 16'h3e00, 16'h7fff, 16'h7fff); endtask
   task automatic s_zero; run("zero", 16'h0000, 16'h4000, 16'h3e00, 16'h3e00, 16'h0000, 16'h3e00); endtask
   initial begin
      repeat (8) @(negedge clk);
      s_accum();
      s_cancel();
      s_round();
      s_ovf();
      s_flush();
      s_addund();
      s_special();
      s_zero();
      final_report();
   end
   initial begin
      #50us;
      err_total++;
      final_report();
   end
endmodule // testbench
